// ### core/sofg_guard.sv
module sofg_guard
   import sofg_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   input  wire logic                   clk_en,
   input  wire logic                   activate_in,
   input  wire logic                   block_in,
   input  wire logic [NUM_TRIG-1:0]    trigger_in,
   input  wire logic [2:0]             logical_node_mode,
   input  wire logic [1:0]             force_status,
   input  wire logic                   release_time_valid,
   input  wire logic [REL_W-1:0]       release_time_ms,
   input  wire logic [SG_W-1:0]        setting_group_used,
   input  wire logic [TS_W-1:0]        timestamp,
   input  wire logic [NUM_COND-1:0]    event_sel_on,
   input  wire logic [NUM_COND-1:0]    event_sel_off,
   input  wire logic                   counter_clear,
   input  wire logic [SNAP_PTR_W-1:0]  snap_rd_idx,
   output logic                        trip_out,
   output logic                        active_out,
   output logic [2:0]                  condition,
   output logic [2:0]                  mode_in_effect,
   output logic [NUM_COND-1:0]         event_on,
   output logic [NUM_COND-1:0]         event_off,
   output logic [TS_W-1:0]             event_time,
   output logic [NUM_COND*CNT_W-1:0]   counters,
   output logic [SNAP_PTR_W-1:0]       snap_count,
   output logic [TS_W-1:0]             snap_time,
   output logic [1:0]                  snap_event,
   output logic [SG_W-1:0]             snap_group,
   output logic [REL_W-1:0]            snap_remaining,
   output logic [REL_W-1:0]            snap_elapsed
);
   localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_DIV - 1);

   // pins pass two flops before any logic reads them
   logic [NUM_TRIG+1:0]    pin_meta;
   logic [NUM_TRIG+1:0]    pin_sync;
   logic                   act_prev;
   logic [TICK_CNT_W-1:0]  tick_cnt;
   logic [REL_W-1:0]       elapsed;
   sofg_state_t            state;
   sofg_state_t            next_state;
   logic [NUM_COND-1:0]    cond_prev;
   logic [SNAP_PTR_W-1:0]  wr_ptr;
   logic [TS_W-1:0]        mem_time [SNAP_DEPTH];
   logic [1:0]             mem_event [SNAP_DEPTH];
   logic [SG_W-1:0]        mem_group [SNAP_DEPTH];
   logic [REL_W-1:0]       mem_rem [SNAP_DEPTH];
   logic [REL_W-1:0]       mem_elapsed [SNAP_DEPTH];

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else if (clk_en) begin
         pin_meta <= {block_in, activate_in, trigger_in};
         pin_sync <= pin_meta;
      end
   end

   // decode of synced pins and mode
   wire             block_s   = pin_sync[NUM_TRIG+1];
   wire             act_s     = pin_sync[NUM_TRIG];
   wire             any_trig  = |pin_sync[NUM_TRIG-1:0];
   wire             act_rise  = act_s & ~act_prev;
   wire sofg_mode_t mode_eff  = (logical_node_mode > 3'(SOFG_MODE_OFF)) ? SOFG_MODE_ON
                                : sofg_mode_t'(logical_node_mode);
   wire             mode_off  = (mode_eff == SOFG_MODE_OFF);
   wire             mode_blk  = (mode_eff == SOFG_MODE_BLOCKED) |
                                (mode_eff == SOFG_MODE_TEST_BLOCKED);
   wire             inhibit   = block_s | mode_blk | mode_off;
   wire             start     = act_rise & ~inhibit;

   // release time, re-read every cycle so a group change takes effect live
   wire [REL_W-1:0] rel_clamp = (release_time_ms > REL_MAX_MS) ? REL_MAX_MS
                                : release_time_ms;
   wire [REL_W-1:0] rel_ms    = release_time_valid ? rel_clamp : REL_DEFAULT_MS;
   wire             expired   = (elapsed >= rel_ms);
   wire [REL_W-1:0] remaining = expired ? '0 : rel_ms - elapsed;
   wire             timer_run = (state != SOFG_ST_IDLE);
   wire             tick      = (tick_cnt == TICK_LAST);

   // ms timebase from the core clock
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         tick_cnt <= '0;
      else if (clk_en)
         tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
   end

   // elapsed time restarts on each accepted start edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         elapsed  <= '0;
         act_prev <= 1'b0;
      end else if (clk_en) begin
         act_prev <= act_s;
         if (start)
            elapsed <= '0;
         else if (timer_run && tick && elapsed != REL_MAX_MS)
            elapsed <= elapsed + 1'b1;
      end
   end

   // arming sequence; block only stops a start, Off mode also aborts
   always_comb begin
      next_state = state;
      case (state)
         SOFG_ST_IDLE:  if (start) next_state = SOFG_ST_INIT;
         SOFG_ST_INIT:  next_state = mode_off ? SOFG_ST_IDLE : SOFG_ST_ARMED;
         SOFG_ST_ARMED: begin
            if (mode_off)
               next_state = SOFG_ST_IDLE;
            else if (start)
               next_state = SOFG_ST_INIT;
            else if (expired)
               next_state = SOFG_ST_IDLE;
         end
         default:       next_state = SOFG_ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         state <= SOFG_ST_IDLE;
      else if (clk_en)
         state <= next_state;
   end

   // computed condition, then the force override on top of it
   wire trip_calc = timer_run & any_trig & ~mode_off;
   wire sofg_cond_t cond_calc = mode_off                 ? SOFG_COND_NORMAL :
                                trip_calc                ? SOFG_COND_TRIP :
                                (state == SOFG_ST_INIT)  ? SOFG_COND_INIT :
                                (state == SOFG_ST_ARMED) ? SOFG_COND_ACTIVE :
                                inhibit                  ? SOFG_COND_BLOCKED :
                                SOFG_COND_NORMAL;
   wire sofg_force_t force_sel = sofg_force_t'(force_status);
   wire sofg_cond_t cond_now   = (force_sel == SOFG_FORCE_BLOCKED) ? SOFG_COND_BLOCKED :
                                 (force_sel == SOFG_FORCE_ACTIVE)  ? SOFG_COND_ACTIVE :
                                 (force_sel == SOFG_FORCE_TRIP)    ? SOFG_COND_TRIP :
                                 cond_calc;

   // trip is combinational so it follows the synced trigger bits with no cycle beyond the two sync flops;
   // test mode shows the trip in the condition but keeps the output quiet
   assign condition      = cond_now;
   assign mode_in_effect = mode_eff;
   assign trip_out       = (cond_now == SOFG_COND_TRIP) & (mode_eff != SOFG_MODE_TEST);
   assign active_out     = (cond_now == SOFG_COND_INIT) | (cond_now == SOFG_COND_ACTIVE) |
                           (cond_now == SOFG_COND_TRIP);

   wire [NUM_COND-1:0] cond_flag;
   assign cond_flag[COND_IDX_INIT]   = (cond_now == SOFG_COND_INIT);
   assign cond_flag[COND_IDX_BLOCK]  = (cond_now == SOFG_COND_BLOCKED);
   assign cond_flag[COND_IDX_ACTIVE] = (cond_now == SOFG_COND_ACTIVE);
   assign cond_flag[COND_IDX_TRIP]   = (cond_now == SOFG_COND_TRIP);
   wire [NUM_COND-1:0] rise = cond_flag & ~cond_prev;
   wire [NUM_COND-1:0] fall = ~cond_flag & cond_prev;

   // per condition: edge events and a counter; a count beats a clear
   genvar gi;
   generate
      for (gi = 0; gi < NUM_COND; gi++) begin : g_cond
         logic [CNT_W-1:0] cnt;
         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               cond_prev[gi] <= 1'b0;
               event_on[gi]  <= 1'b0;
               event_off[gi] <= 1'b0;
               cnt           <= '0;
            end else if (clk_en) begin
               cond_prev[gi] <= cond_flag[gi];
               event_on[gi]  <= rise[gi] & event_sel_on[gi];
               event_off[gi] <= fall[gi] & event_sel_off[gi];
               if (rise[gi])
                  cnt <= counter_clear ? CNT_W'(1) : cnt + 1'b1;
               else if (counter_clear)
                  cnt <= '0;
            end
         end
         assign counters[gi*CNT_W +: CNT_W] = cnt;
      end
   endgenerate

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         event_time <= '0;
      else if (clk_en && (|rise || |fall))
         event_time <= timestamp;
   end

   // snapshot ring; simultaneous ON edges keep only the most severe one
   wire       any_rise = |rise;
   wire [1:0] snap_id  = rise[COND_IDX_TRIP]   ? EV_ID_TRIP :
                         rise[COND_IDX_ACTIVE] ? EV_ID_ACTIVE :
                         rise[COND_IDX_BLOCK]  ? EV_ID_BLOCK : EV_ID_INIT;
   wire [SNAP_PTR_W:0]   back   = {1'b0, wr_ptr} + 5'(SNAP_DEPTH - 1) - {1'b0, snap_rd_idx};
   wire [SNAP_PTR_W:0]   wrap   = (back >= 5'(SNAP_DEPTH)) ? back - 5'(SNAP_DEPTH) : back;
   wire [SNAP_PTR_W-1:0] rd_ptr = wrap[SNAP_PTR_W-1:0];

   always_ff @(posedge core_clk) begin
      if (clk_en && any_rise) begin
         mem_time[wr_ptr]    <= timestamp;
         mem_event[wr_ptr]   <= snap_id;
         mem_group[wr_ptr]   <= setting_group_used;
         mem_rem[wr_ptr]     <= remaining;
         mem_elapsed[wr_ptr] <= elapsed;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr     <= '0;
         snap_count <= '0;
      end else if (clk_en && any_rise) begin
         wr_ptr <= (wr_ptr == SNAP_LAST) ? '0 : wr_ptr + 1'b1;
         if (snap_count != 4'(SNAP_DEPTH))
            snap_count <= snap_count + 1'b1;
      end
   end

   // read port, index 0 is the newest record; stale slots read as zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         snap_time      <= '0;
         snap_event     <= '0;
         snap_group     <= '0;
         snap_remaining <= '0;
         snap_elapsed   <= '0;
      end else if (clk_en) begin
         snap_time      <= (snap_rd_idx < snap_count) ? mem_time[rd_ptr] : '0;
         snap_event     <= (snap_rd_idx < snap_count) ? mem_event[rd_ptr] : '0;
         snap_group     <= (snap_rd_idx < snap_count) ? mem_group[rd_ptr] : '0;
         snap_remaining <= (snap_rd_idx < snap_count) ? mem_rem[rd_ptr] : '0;
         snap_elapsed   <= (snap_rd_idx < snap_count) ? mem_elapsed[rd_ptr] : '0;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_start;
      clk_en && state == SOFG_ST_IDLE && act_rise && !inhibit;
   endsequence
   sequence s_armed;
      state == SOFG_ST_INIT ##1 (!clk_en || state == SOFG_ST_ARMED || mode_off);
   endsequence

   a_arm_on_edge: assert property (s_start |=> s_armed)
      else $error("start edge did not arm the window");
   a_block_no_start: assert property (
      clk_en && state == SOFG_ST_IDLE && inhibit |=> state == SOFG_ST_IDLE)
      else $error("window started while blocked");
   a_trip_immediate: assert property (
      timer_run && any_trig && !mode_off && force_sel == SOFG_FORCE_NORMAL
      && mode_eff != SOFG_MODE_TEST |-> trip_out)
      else $error("trigger in window did not trip at once");
   a_expire_normal: assert property (
      clk_en && state == SOFG_ST_ARMED && expired && !start |=> state == SOFG_ST_IDLE)
      else $error("window did not close at expiry");
   a_force_override: assert property (
      force_sel == SOFG_FORCE_TRIP |-> condition == SOFG_COND_TRIP && active_out)
      else $error("forced trip not reflected");
   a_default_release: assert property (!release_time_valid |-> rel_ms == 21'h0003E8)
      else $error("release time default wrong");
   a_trip_count: assert property (
      clk_en && rise[COND_IDX_TRIP] && !counter_clear
      |=> g_cond[COND_IDX_TRIP].cnt == $past(g_cond[COND_IDX_TRIP].cnt) + 1'b1)
      else $error("trip counter did not advance");
   a_snap_fill: assert property (
      clk_en && any_rise && snap_count < 4'hC |=> snap_count == $past(snap_count) + 1'b1)
      else $error("snapshot count did not advance");
   a_event_select: assert property (
      clk_en && rise[COND_IDX_ACTIVE] |=> event_on[COND_IDX_ACTIVE] == $past(event_sel_on[2]))
      else $error("active ON event selection wrong");
endmodule

// ### core/sofg_pkg.sv
package sofg_pkg;
   // clock and timebase
   localparam int CLK_PERIOD_NS  = 50;
   localparam int TICK_PERIOD_NS = 1000000;           // release timer counts in ms
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_CNT_W     = 15;

   // release time, in ms ticks
   localparam int          REL_W          = 21;
   localparam logic [20:0] REL_DEFAULT_MS = 21'h0003E8; // 1.000 s
   localparam logic [20:0] REL_MAX_MS     = 21'h1B7740; // 1800.000 s

   // widths and sizes
   localparam int NUM_TRIG   = 8;
   localparam int NUM_COND   = 4;
   localparam int CNT_W      = 16;
   localparam int TS_W       = 48;
   localparam int SG_W       = 3;
   localparam int SNAP_DEPTH = 12;
   localparam int SNAP_PTR_W = 4;
   localparam logic [3:0] SNAP_LAST = 4'hB;

   // condition indices for events, counters and snapshot identity
   localparam int COND_IDX_INIT   = 0;
   localparam int COND_IDX_BLOCK  = 1;
   localparam int COND_IDX_ACTIVE = 2;
   localparam int COND_IDX_TRIP   = 3;
   localparam logic [1:0] EV_ID_INIT   = 2'h0;
   localparam logic [1:0] EV_ID_BLOCK  = 2'h1;
   localparam logic [1:0] EV_ID_ACTIVE = 2'h2;
   localparam logic [1:0] EV_ID_TRIP   = 2'h3;

   typedef enum logic [2:0] {
      SOFG_MODE_ON           = 3'b000,
      SOFG_MODE_BLOCKED      = 3'b001,
      SOFG_MODE_TEST         = 3'b010,
      SOFG_MODE_TEST_BLOCKED = 3'b011,
      SOFG_MODE_OFF          = 3'b100
   } sofg_mode_t;

   typedef enum logic [1:0] {
      SOFG_FORCE_NORMAL  = 2'b00,
      SOFG_FORCE_BLOCKED = 2'b01,
      SOFG_FORCE_ACTIVE  = 2'b10,
      SOFG_FORCE_TRIP    = 2'b11
   } sofg_force_t;

   typedef enum logic [2:0] {
      SOFG_COND_NORMAL  = 3'b000,
      SOFG_COND_INIT    = 3'b001,
      SOFG_COND_ACTIVE  = 3'b010,
      SOFG_COND_TRIP    = 3'b011,
      SOFG_COND_BLOCKED = 3'b100
   } sofg_cond_t;

   typedef enum logic [1:0] {
      SOFG_ST_IDLE  = 2'b00,
      SOFG_ST_INIT  = 2'b01,
      SOFG_ST_ARMED = 2'b10
   } sofg_state_t;
endpackage

// ### dv/sofg_far_end.sv
module sofg_far_end
   import sofg_pkg::*;
(
   input  wire logic                close_cmd,
   input  wire logic                dig_in,
   input  wire logic                inhibit,
   input  wire logic [NUM_TRIG-1:0] fault_start,
   output logic                     activate_in,
   output logic                     block_in,
   output logic [NUM_TRIG-1:0]      trigger_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // either a digital input or a breaker close command arms the window
   assign activate_in = close_cmd | dig_in;
   // protection start signals and block fan straight in, no filtering
   assign block_in    = inhibit;
   assign trigger_in  = fault_start;
endmodule

// ### dv/test_switch_onto_fault_guard.sv
module test_switch_onto_fault_guard
   import sofg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // short prescaler keeps a 1 s window at 4000 cycles
   localparam int TDIV = 4;
   logic                        core_clk;
   logic                        nrst;
   logic                        clk_en;
   logic                        close_cmd;
   logic                        dig_in;
   logic                        inhibit;
   logic [NUM_TRIG-1:0]         fault_start;
   logic                        activate_in;
   logic                        block_in;
   logic [NUM_TRIG-1:0]         trigger_in;
   logic [2:0]                  logical_node_mode;
   logic [1:0]                  force_status;
   logic                        release_time_valid;
   logic [REL_W-1:0]            release_time_ms;
   logic [SG_W-1:0]             setting_group_used;
   logic [TS_W-1:0]             timestamp;
   logic [NUM_COND-1:0]         event_sel_on;
   logic [NUM_COND-1:0]         event_sel_off;
   logic                        counter_clear;
   logic [SNAP_PTR_W-1:0]       snap_rd_idx;
   logic                        trip_out;
   logic                        active_out;
   logic [2:0]                  condition;
   logic [2:0]                  mode_in_effect;
   logic [NUM_COND-1:0]         event_on;
   logic [NUM_COND-1:0]         event_off;
   logic [TS_W-1:0]             event_time;
   logic [NUM_COND*CNT_W-1:0]   counters;
   logic [SNAP_PTR_W-1:0]       snap_count;
   logic [TS_W-1:0]             snap_time;
   logic [1:0]                  snap_event;
   logic [SG_W-1:0]             snap_group;
   logic [REL_W-1:0]            snap_remaining;
   logic [REL_W-1:0]            snap_elapsed;
   int                          n_errors = 0;
   int                          cmp_count = 0;
   sofg_cond_t                  exp_force [4] = '{SOFG_COND_NORMAL, SOFG_COND_BLOCKED,
                                                  SOFG_COND_ACTIVE, SOFG_COND_TRIP};

   sofg_far_end i_far (.close_cmd(close_cmd), .dig_in(dig_in), .inhibit(inhibit),
      .fault_start(fault_start), .activate_in(activate_in), .block_in(block_in),
      .trigger_in(trigger_in));

   sofg_guard #(.TICK_DIV(TDIV)) i_dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .activate_in(activate_in), .block_in(block_in), .trigger_in(trigger_in),
      .logical_node_mode(logical_node_mode), .force_status(force_status),
      .release_time_valid(release_time_valid), .release_time_ms(release_time_ms),
      .setting_group_used(setting_group_used), .timestamp(timestamp),
      .event_sel_on(event_sel_on), .event_sel_off(event_sel_off),
      .counter_clear(counter_clear), .snap_rd_idx(snap_rd_idx), .trip_out(trip_out),
      .active_out(active_out), .condition(condition), .mode_in_effect(mode_in_effect),
      .event_on(event_on), .event_off(event_off), .event_time(event_time),
      .counters(counters), .snap_count(snap_count), .snap_time(snap_time),
      .snap_event(snap_event), .snap_group(snap_group), .snap_remaining(snap_remaining),
      .snap_elapsed(snap_elapsed));

   // 20 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic print_verdict();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // inputs move only at falling edges, away from the sampling edge
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // rising arm source; returns in the single init cycle (sync plus edge detect)
   task automatic arm(input logic by_close);
      if (by_close) close_cmd = 1'b1;
      else dig_in = 1'b1;
      cyc(3);
      close_cmd = 1'b0;
      dig_in    = 1'b0;
   endtask

   // whole run is about 4500 cycles, so this only fires on a hang
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      print_verdict();
   end

   initial begin
      nrst = 1'b0;
      clk_en = 1'b1;
      close_cmd = 1'b0;
      dig_in = 1'b0;
      inhibit = 1'b0;
      fault_start = 8'h00;
      logical_node_mode = SOFG_MODE_ON;
      force_status = SOFG_FORCE_NORMAL;
      release_time_valid = 1'b0;
      release_time_ms = 21'h00000A;
      setting_group_used = 3'h5;
      timestamp = 48'h000000000000;
      event_sel_on = 4'hF;
      event_sel_off = 4'hF;
      counter_clear = 1'b0;
      snap_rd_idx = 4'h0;
      cyc(12);
      nrst = 1'b1;
      cyc(3);
      chk("condition", SOFG_COND_NORMAL, condition);
      chk("counters", 64'h0, counters);
      chk("snap_count", 4'h0, snap_count);
      // default window from a digital input
      arm(1'b0);
      chk("condition", SOFG_COND_INIT, condition);
      cyc(1);
      chk("condition", SOFG_COND_ACTIVE, condition);
      chk("event_on", 4'h1, event_on);
      cyc(3900);
      chk("condition", SOFG_COND_ACTIVE, condition);
      cyc(150);
      chk("condition", SOFG_COND_NORMAL, condition);
      chk("active_out", 1'b0, active_out);
      // short window from a close command, fault mid-way
      release_time_valid = 1'b1;
      timestamp = 48'h00000000ABCD;
      arm(1'b1);
      cyc(9);
      fault_start = 8'h80;
      cyc(2);
      chk("trip_out", 1'b1, trip_out);
      chk("condition", SOFG_COND_TRIP, condition);
      cyc(1);
      chk("event_on", 4'h8, event_on);
      chk("event_off", 4'h4, event_off);
      chk("event_time", 48'h00000000ABCD, event_time);
      chk("trip count", 64'h1, counters[63:48]);
      cyc(2);
      chk("snap_count", 4'h5, snap_count);
      chk("snap_event", EV_ID_TRIP, snap_event);
      chk("snap_group", 3'h5, snap_group);
      chk("snap_time", 48'h00000000ABCD, snap_time);
      chk("snap sum", 64'hA, 64'(snap_remaining) + 64'(snap_elapsed));
      snap_rd_idx = 4'h1;
      cyc(2);
      chk("snap_event", EV_ID_ACTIVE, snap_event);
      snap_rd_idx = 4'h0;
      fault_start = 8'h00;
      cyc(2);
      chk("trip_out", 1'b0, trip_out);
      cyc(60);
      chk("condition", SOFG_COND_NORMAL, condition);
      // unselected init event, then stretch the window while running
      event_sel_on = 4'hE;
      arm(1'b0);
      cyc(1);
      chk("event_on", 4'h0, event_on);
      release_time_ms = 21'h000028;
      cyc(100);
      chk("condition", SOFG_COND_ACTIVE, condition);
      cyc(90);
      chk("condition", SOFG_COND_NORMAL, condition);
      event_sel_on = 4'hF;
      release_time_ms = 21'h00000A;
      // clock enable low freezes even the pin synchronisers
      clk_en = 1'b0;
      arm(1'b0);
      clk_en = 1'b1;
      cyc(3);
      chk("condition", SOFG_COND_NORMAL, condition);
      // block input stops arming, so a trigger cannot trip
      inhibit = 1'b1;
      cyc(3);
      chk("condition", SOFG_COND_BLOCKED, condition);
      arm(1'b1);
      fault_start = 8'h01;
      cyc(3);
      chk("condition", SOFG_COND_BLOCKED, condition);
      chk("trip_out", 1'b0, trip_out);
      fault_start = 8'h00;
      inhibit = 1'b0;
      cyc(3);
      chk("condition", SOFG_COND_NORMAL, condition);
      // active counts again when a trip ends inside the window
      chk("counters", 64'h0001000400010003, counters);
      // every mode code is reported, blocking ones inhibit, spare codes act as On
      for (int m = 0; m < 8; m++) begin
         logical_node_mode = 3'(m);
         cyc(3);
         chk("mode_in_effect", (m < 5) ? 64'(m) : 64'h0, mode_in_effect);
         if (m == 1 || m == 3) chk("condition", SOFG_COND_BLOCKED, condition);
      end
      // test mode shows the trip but keeps the output quiet
      logical_node_mode = SOFG_MODE_TEST;
      cyc(3);
      arm(1'b0);
      cyc(3);
      fault_start = 8'h02;
      cyc(2);
      chk("condition", SOFG_COND_TRIP, condition);
      chk("trip_out", 1'b0, trip_out);
      fault_start = 8'h00;
      logical_node_mode = SOFG_MODE_ON;
      cyc(60);
      // forced status overrides the idle condition
      for (int f = 0; f < 4; f++) begin
         force_status = 2'(f);
         cyc(2);
         chk("condition", exp_force[f], condition);
      end
      chk("trip_out", 1'b1, trip_out);
      force_status = SOFG_FORCE_NORMAL;
      cyc(3);
      // ring has wrapped by now: full count, newest first
      chk("snap_count", 4'hC, snap_count);
      chk("snap_event", EV_ID_TRIP, snap_event);
      snap_rd_idx = 4'h2;
      cyc(2);
      chk("snap_event", EV_ID_BLOCK, snap_event);
      counter_clear = 1'b1;
      cyc(2);
      counter_clear = 1'b0;
      cyc(1);
      chk("counters", 64'h0, counters);
      // reset in mid-window drops everything back to idle
      arm(1'b0);
      nrst = 1'b0;
      cyc(2);
      nrst = 1'b1;
      cyc(3);
      chk("condition", SOFG_COND_NORMAL, condition);
      chk("snap_count", 4'h0, snap_count);
      chk("snap_time", 48'h0, snap_time);
      print_verdict();
   end
endmodule
